// ==== hdl/converter_config_control_regs.vh ====
// Register offsets, field positions and reset values of the config bank
`ifndef CONVERTER_CONFIG_CONTROL_REGS_VH
`define CONVERTER_CONFIG_CONTROL_REGS_VH

// ============================================================
// Byte addresses (one aligned word per register)
`define ADDR_MODE_SNAPSHOT 12'h018
`define ADDR_CHIP_CONTROL 12'h01C
`define ADDR_LOW_SIDE_TRIM 12'h020
`define ADDR_HIGH_SIDE_TRIM 12'h024
`define ADDR_REF_CURRENT_TRIM 12'h028
`define ADDR_SPREAD_SPECTRUM_CTL 12'h02C
`define ADDR_IRQ_STATUS 12'h040
`define ADDR_IRQ_MASK 12'h044

// ============================================================
// Mode snapshot fields
`define MODE_BURST_BIT 4
`define MODE_DISCONT_BIT 3
`define MODE_HIGH_IMP_BIT 2
`define MODE_SPREAD_BIT 1
`define MODE_DIR_BIT 0

// ============================================================
// Chip control fields
`define CTL_FAULT_BIT 2
`define CTL_RESTORE_BIT 1
`define CTL_PROTECT_BIT 0

// ============================================================
// Widths and reset values
`define TRIM7_W 7
`define TRIM5_W 5
`define SPREAD_W 5
`define RST_TRIM7 7'h00
`define RST_TRIM5 5'h00
`define RST_SPREAD 5'h00
`define RST_CTL 3'h0

// ============================================================
// Interrupt status bits
`define IRQ_W 2
`define IRQ_FAULT_BIT 0
`define IRQ_MODE_BIT 1

`endif

// ==== hdl/converter_config_control_regs.v ====
// APB register bank of the multi-phase bidirectional converter controller
// ============================================================
// Overview of operation
// - Mode snapshot read-only, bits 7:5 reserved
// - Mode bits: burst, discontinuous, high-impedance, spread
// - Bit 0 reads 1 buck, 0 boost
// - PEC write fault sets flag; write-one clears
// - Restore bit returns read-write registers to defaults
// - Write protect drops trim and spread writes
// - Low-side trim seven-bit two's complement code
// - Low-side trim applied only in buck
// - High-side trim same seven-bit format
// - High-side trim applied only in boost
// - Reference trim five-bit, bit 4 removes base
// - Reference trim resets zero, nominal 16 uA
// - Spread control and trims reset to zero
`timescale 1ns/1ps
`include "converter_config_control_regs.vh"

module converter_config_control_regs #(
	parameter ADDR_W = 12
) (
	input wire core_clk,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire burst_mode_pin,
	input wire discontinuous_conduction_pin,
	input wire high_impedance_pin,
	input wire spread_active_pin,
	input wire buck_direction_pin,
	input wire pec_error,
	output reg [`TRIM7_W-1:0] low_side_feedback,
	output reg low_side_enable,
	output reg [`TRIM7_W-1:0] high_side_feedback,
	output reg high_side_enable,
	output reg [`TRIM5_W-1:0] ref_current_pin,
	output reg [`SPREAD_W-1:0] spread_ctl,
	output reg write_protect,
	output wire irq
);

	// ============================================================
	// Pin synchronisers (two flops, first read only by second)
	reg [5:0] pin_meta;
	reg [5:0] pin_sync;
	always @(posedge core_clk) begin
		if (sys_rst) begin
			pin_meta <= 6'h00;
			pin_sync <= 6'h00;
		end else begin
			pin_meta <= {pec_error, burst_mode_pin,
				discontinuous_conduction_pin, high_impedance_pin,
				spread_active_pin, buck_direction_pin};
			pin_sync <= pin_meta;
		end
	end

	wire pec_sync = pin_sync[5];
	wire buck_mode = pin_sync[0];
	reg pec_prev;

	// Snapshot of pin-programmed modes, upper bits zero
	wire [7:0] mode_snapshot = {3'h0,
		pin_sync[4], // Burst
		pin_sync[3], // Discontinuous conduction
		pin_sync[2], // High impedance
		pin_sync[1], // Spread spectrum
		buck_mode}; // 1 buck, 0 boost

	// ============================================================
	// APB decode; single-cycle access phase, never stalls
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	wire access = psel & penable;
	wire wr = access & pwrite & pstrb[0];
	wire rd = access & ~pwrite;

	function hit;
		input [ADDR_W-1:0] a;
		input [11:0] b;
		begin
			hit = (a == b[ADDR_W-1:0]);
		end
	endfunction

	// ============================================================
	// Registers
	reg comm_fault_flag;
	reg [`TRIM7_W-1:0] low_side_trim;
	reg [`TRIM7_W-1:0] high_side_trim;
	reg [`TRIM5_W-1:0] ref_current_trim;
	reg [`SPREAD_W-1:0] spread_spectrum_ctl;
	reg [`IRQ_W-1:0] irq_status;
	reg [`IRQ_W-1:0] irq_mask;
	reg [4:0] mode_prev;

	wire pec_event = pec_sync & ~pec_prev;
	wire mode_event = (mode_snapshot[4:0] != mode_prev);
	wire ctl_wr = wr & hit(paddr, `ADDR_CHIP_CONTROL);
	// Restore takes effect in the write cycle; the bit itself reads 0
	wire restore = ctl_wr & pwdata[`CTL_RESTORE_BIT];
	// Protected writes are dropped silently, no bus error
	wire trim_wr_ok = wr & ~write_protect;

	always @(posedge core_clk) begin
		if (sys_rst || restore) begin
			low_side_trim <= `RST_TRIM7;
			high_side_trim <= `RST_TRIM7;
			ref_current_trim <= `RST_TRIM5;
			spread_spectrum_ctl <= `RST_SPREAD;
			write_protect <= 1'b0;
			irq_mask <= {`IRQ_W{1'b0}};
		end else begin
			if (ctl_wr)
				write_protect <= pwdata[`CTL_PROTECT_BIT];
			if (trim_wr_ok && hit(paddr, `ADDR_LOW_SIDE_TRIM))
				low_side_trim <= pwdata[`TRIM7_W-1:0];
			if (trim_wr_ok && hit(paddr, `ADDR_HIGH_SIDE_TRIM))
				high_side_trim <= pwdata[`TRIM7_W-1:0];
			if (trim_wr_ok && hit(paddr, `ADDR_REF_CURRENT_TRIM))
				ref_current_trim <= pwdata[`TRIM5_W-1:0];
			if (trim_wr_ok && hit(paddr, `ADDR_SPREAD_SPECTRUM_CTL))
				spread_spectrum_ctl <= pwdata[`SPREAD_W-1:0];
			if (wr && hit(paddr, `ADDR_IRQ_MASK))
				irq_mask <= pwdata[`IRQ_W-1:0];
		end
	end

	// Fault flag: hardware set wins over write-one clear
	always @(posedge core_clk) begin
		if (sys_rst) begin
			comm_fault_flag <= 1'b0;
			pec_prev <= 1'b0;
			mode_prev <= 5'h00;
		end else begin
			pec_prev <= pec_sync;
			mode_prev <= mode_snapshot[4:0];
			if (pec_event)
				comm_fault_flag <= 1'b1;
			else if (ctl_wr && pwdata[`CTL_FAULT_BIT])
				comm_fault_flag <= 1'b0;
		end
	end

	// Sticky interrupt status, cleared by reading it; new event wins
	wire irq_rd = rd & hit(paddr, `ADDR_IRQ_STATUS);
	wire [`IRQ_W-1:0] irq_set = {mode_event, pec_event};
	always @(posedge core_clk) begin
		if (sys_rst)
			irq_status <= {`IRQ_W{1'b0}};
		else if (irq_rd)
			// Clear only what the read reported; a late event survives
			irq_status <= (irq_status & ~prdata[`IRQ_W-1:0]) | irq_set;
		else
			irq_status <= irq_status | irq_set;
	end
	assign irq = |(irq_status & irq_mask);

	// ============================================================
	// Read data, registered in the setup cycle
	reg [31:0] next_prdata;
	always @* begin
		next_prdata = 32'h00000000;
		if (hit(paddr, `ADDR_MODE_SNAPSHOT))
			next_prdata[7:0] = mode_snapshot;
		else if (hit(paddr, `ADDR_CHIP_CONTROL))
			next_prdata[`CTL_FAULT_BIT:0] =
				{comm_fault_flag, 1'b0, write_protect};
		else if (hit(paddr, `ADDR_LOW_SIDE_TRIM))
			next_prdata[`TRIM7_W-1:0] = low_side_trim;
		else if (hit(paddr, `ADDR_HIGH_SIDE_TRIM))
			next_prdata[`TRIM7_W-1:0] = high_side_trim;
		else if (hit(paddr, `ADDR_REF_CURRENT_TRIM))
			next_prdata[`TRIM5_W-1:0] = ref_current_trim;
		else if (hit(paddr, `ADDR_SPREAD_SPECTRUM_CTL))
			next_prdata[`SPREAD_W-1:0] = spread_spectrum_ctl;
		else if (hit(paddr, `ADDR_IRQ_STATUS))
			next_prdata[`IRQ_W-1:0] = irq_status;
		else if (hit(paddr, `ADDR_IRQ_MASK))
			next_prdata[`IRQ_W-1:0] = irq_mask;
	end

	// prdata is a register loaded from the next_prdata mux above:
	// the setup cycle loads it so it is stable in the access phase
	always @(posedge core_clk) begin
		if (sys_rst)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite)
			prdata <= next_prdata;
	end

	// ============================================================
	// Trim outputs toward the current DACs, enables set by direction
	always @(posedge core_clk) begin
		if (sys_rst) begin
			low_side_feedback <= {`TRIM7_W{1'b0}};
			high_side_feedback <= {`TRIM7_W{1'b0}};
			low_side_enable <= 1'b0;
			high_side_enable <= 1'b0;
			ref_current_pin <= {`TRIM5_W{1'b0}};
			spread_ctl <= {`SPREAD_W{1'b0}};
		end else begin
			low_side_feedback <= low_side_trim;
			high_side_feedback <= high_side_trim;
			low_side_enable <= buck_mode;
			high_side_enable <= ~buck_mode;
			ref_current_pin <= ref_current_trim;
			spread_ctl <= spread_spectrum_ctl;
		end
	end

endmodule // converter_config_control_regs

// ==== tb/cfg_bank_props.sv ====
// Assertion checker for the converter config bank
`timescale 1ns/1ps
// ==========
// Checker
module cfg_bank_props (
	input wire core_clk,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	input wire [31:0] prdata,
	input wire buck_direction_pin,
	input wire [6:0] low_side_feedback,
	input wire low_side_enable,
	input wire high_side_enable,
	input wire write_protect
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire wr = psel && penable && pwrite && pstrb[0];
	wire wr_ctl = wr && paddr == 12'h01C;
	wire wr_low = wr && paddr == 12'h020;
	// The feedback outputs trail the register by a cycle, so look two edges on
	wp_set_a: assert property (wr_ctl && !pwdata[1] |=> ##1
		write_protect == $past(pwdata[0], 2)) else $error("wp wrong");
	restore_clear_a: assert property (wr_ctl && pwdata[1] |=> ##1
		!write_protect && low_side_feedback == 7'h00) else $error("no restore");
	side_excl_a: assert property (!(low_side_enable && high_side_enable))
		else $error("both trims on");
	buck_side_a: assert property (buck_direction_pin [*5] |-> low_side_enable)
		else $error("low trim off");
	boost_side_a: assert property (!buck_direction_pin [*5] |-> high_side_enable)
		else $error("high trim off");
	reserved_zero_a: assert property (psel && penable && !pwrite |->
		prdata[31:8] == 24'h000000) else $error("upper bits set");
	trim_write_a: assert property (wr_low && !write_protect |=> ##1
		low_side_feedback == $past(pwdata[6:0], 2)) else $error("trim lost");
	wp_drop_a: assert property (wr_low && write_protect |=> ##1
		$stable(low_side_feedback)) else $error("trim changed");
	cover property (wr_ctl && pwdata[1]);
	cover property (wr_ctl && pwdata[0]);
	cover property (wr_low && write_protect);
endmodule // cfg_bank_props

bind converter_config_control_regs cfg_bank_props chk (.core_clk, .sys_rst,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
	.buck_direction_pin, .low_side_feedback, .low_side_enable,
	.high_side_enable, .write_protect);

// ==== tb/host_apb.sv ====
// Host model driving the bank's APB port
`timescale 1ns/1ps
// ==========
// Host
module host_apb (
	input wire core_clk,
	input wire pready,
	input wire [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb
);
	logic hung = 1'b0;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
	end
	// Request held until pready is seen high at an edge
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		hung = hung || n >= 50;
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // host_apb

// ==== tb/tb_converter_config_control_regs.sv ====
// Self-checking bench for the converter config bank
`timescale 1ns/1ps
// ==========
// Bench
module tb_converter_config_control_regs;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel, penable, pwrite, pready, irq, low_en, high_en, pec = 1'b0;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] pstrb;
	logic [4:0] pins = 5'h00;
	logic [6:0] low_fb, high_fb;
	logic [4:0] ref_pin, spread_out;
	logic slverr;
	int error_cnt = 0;
	int check_count = 0;
	always #12.5 core_clk = ~core_clk;
	converter_config_control_regs dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(slverr), .burst_mode_pin(pins[4]),
		.discontinuous_conduction_pin(pins[3]), .high_impedance_pin(pins[2]),
		.spread_active_pin(pins[1]), .buck_direction_pin(pins[0]),
		.pec_error(pec), .low_side_feedback(low_fb), .low_side_enable(low_en),
		.high_side_feedback(high_fb), .high_side_enable(high_en),
		.ref_current_pin(ref_pin), .spread_ctl(spread_out), .write_protect(),
		.irq(irq));
	host_apb h (.core_clk(core_clk), .pready(pready), .prdata(prdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb));
	task give_verdict();
		if (h.hung) error_cnt++;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		h.xfer(1'b1, a, d, q);
		if (h.hung) give_verdict();
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		h.xfer(1'b0, a, 32'h0, q);
		if (h.hung) give_verdict();
		chk(q, e);
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(12'h028, 32'h0);
		rd(12'h02C, 32'h0);
		rd(12'h020, 32'h0);
		$display("reset test done");
		pins <= 5'h15;
		repeat (4) @(posedge core_clk);
		wr(12'h018, 32'hFFFFFFFF);
		rd(12'h018, 32'h15);
		chk({low_en, high_en}, 32'h2);
		pins <= 5'h0A;
		repeat (4) @(posedge core_clk);
		rd(12'h018, 32'h0A);
		chk({low_en, high_en}, 32'h1);
		$display("mode test done");
		wr(12'h020, 32'hFFFFFFFF);
		rd(12'h020, 32'h7F);
		chk(low_fb, 32'h7F);
		wr(12'h024, 32'hC0);
		rd(12'h024, 32'h40);
		chk(high_fb, 32'h40);
		wr(12'h028, 32'hFF);
		rd(12'h028, 32'h1F);
		chk(ref_pin, 32'h1F);
		wr(12'h02C, 32'hFF);
		wr(12'h01C, 32'h1);
		wr(12'h020, 32'h0);
		wr(12'h02C, 32'h0);
		rd(12'h020, 32'h7F);
		rd(12'h02C, 32'h1F);
		chk(spread_out, 32'h1F);
		chk(slverr, 32'h0);
		wr(12'h01C, 32'h0);
		wr(12'h020, 32'h05);
		rd(12'h020, 32'h05);
		$display("trim test done");
		chk(irq, 32'h0);
		rd(12'h040, 32'h2);
		wr(12'h044, 32'h1);
		pec <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk(irq, 32'h1);
		rd(12'h01C, 32'h4);
		wr(12'h01C, 32'h4);
		rd(12'h01C, 32'h0);
		rd(12'h040, 32'h1);
		@(posedge core_clk);
		chk(irq, 32'h0);
		$display("fault test done");
		wr(12'h01C, 32'h3);
		rd(12'h020, 32'h0);
		rd(12'h02C, 32'h0);
		chk(ref_pin, 32'h0);
		chk(spread_out, 32'h0);
		rd(12'h01C, 32'h0);
		rd(12'h100, 32'h0);
		$display("restore test done");
		give_verdict();
	end
endmodule // tb_converter_config_control_regs
